// ### hdl/rtc_link_if.sv
`timescale 1ns/1ns
interface rtc_link_if;
  logic [15:0][7:0] snap;
  logic wr_tgl;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  modport link (input snap, output wr_tgl, output wr_addr, output wr_data);
  modport core (output snap, input wr_tgl, input wr_addr, input wr_data);
endinterface

// ### hdl/rtc_pkg.sv
// Contract
// - all timekeeping derives from the external 32.768kHz crystal input only
// - reads address 00h-0Fh, writes 80h-8Fh; top address bit means write
// - address pointer advances per byte, wraps from 0Fh to 00h
// - time copied to secondary set on chip-select falling edge
// - reads return the secondary copy while live counters keep running
// - time, calendar and alarm values are packed BCD
// - hours bit 6 selects 12-hour mode; bit 5 then means PM
// - century bit 7 of month inverts when year rolls 99 to 00
// - alarm match sets the alarm flag in status to one
package rtc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned NREG = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned WRITE_BIT = 7;
  localparam logic [3:0] REG_HUND = 4'h0;
  localparam logic [3:0] REG_SEC = 4'h1;
  localparam logic [3:0] REG_MIN = 4'h2;
  localparam logic [3:0] REG_HOUR = 4'h3;
  localparam logic [3:0] REG_WDAY = 4'h4;
  localparam logic [3:0] REG_MDAY = 4'h5;
  localparam logic [3:0] REG_MON = 4'h6;
  localparam logic [3:0] REG_YEAR = 4'h7;
  localparam logic [3:0] REG_A_HUND = 4'h8;
  localparam logic [3:0] REG_A_SEC = 4'h9;
  localparam logic [3:0] REG_A_MIN = 4'hA;
  localparam logic [3:0] REG_A_HOUR = 4'hB;
  localparam logic [3:0] REG_A_DAY = 4'hC;
  localparam logic [3:0] REG_CTRL = 4'hD;
  localparam logic [3:0] REG_STAT = 4'hE;
  localparam logic [3:0] REG_CHARGE = 4'hF;
  // writable bits per register, index 15 first
  localparam logic [15:0][7:0] REG_MASK = {
    8'hFF, 8'h81, 8'hBD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h9F, 8'h3F, 8'h07, 8'h7F, 8'h7F, 8'h7F, 8'hFF};
  // status comes up with the halted flag set; calendar at day one
  localparam logic [15:0][7:0] REG_RESET = {
    8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned HOUR_MODE_BIT = 6;
  localparam int unsigned HOUR_PM_BIT = 5;
  localparam int unsigned CENTURY_BIT = 7;
  localparam int unsigned ALARM_MASK_BIT = 7;
  localparam int unsigned DAYSEL_BIT = 6;
  localparam int unsigned OSC_STOP_BIT = 7;
  localparam int unsigned BACKUP_OUT_BIT = 5;
  localparam int unsigned RATE_HI_BIT = 4;
  localparam int unsigned RATE_LO_BIT = 3;
  localparam int unsigned IRQ_SEL_BIT = 2;
  localparam int unsigned AIE_BIT = 0;
  localparam int unsigned OSC_HALT_BIT = 7;
  localparam int unsigned ALARM_FLAG_BIT = 0;
  // ----------------------------------------------------------------
  // bcd limits
  // ----------------------------------------------------------------
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [4:0] BCD_11 = 5'h11;
  localparam logic [7:0] BCD_7 = 8'h07;
  localparam logic [4:0] MON_FEB = 5'h02;
  localparam logic [4:0] MON_APR = 5'h04;
  localparam logic [4:0] MON_JUN = 5'h06;
  localparam logic [4:0] MON_SEP = 5'h09;
  localparam logic [4:0] MON_NOV = 5'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] ALARM_EVERY = 8'hFF;
  localparam logic [3:0] ALARM_TENTHS_ANY = 4'hF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned SUB_HZ = 4096;
  localparam int unsigned PRESCALE = XTAL_HZ / SUB_HZ;
  localparam int unsigned XDIV_W = 15;
  localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE - 1);
  localparam logic [5:0] DIV_LONG_LAST = 6'h28;
  localparam logic [5:0] DIV_SHORT_LAST = 6'h27;
  localparam logic [4:0] DIV_LONG_RUNS = 5'h18;
  localparam int unsigned WAVE_BIT_1HZ = 14;
  localparam int unsigned WAVE_BIT_4K = 2;
  localparam int unsigned WAVE_BIT_8K = 1;
  localparam logic [2:0] SYNC_RESET = 3'b010;
endpackage

// ### hdl/rtc_register_map_snapshot.sv
`timescale 1ns/1ns
module rtc_register_map_snapshot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic xtal_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic wave_or_irq_out_oe
);
  rtc_link_if link ();

  logic [2:0] sync_meta, sync_live, sync_prev;
  logic [2:0] next_sync_meta, next_sync_live, next_sync_prev;
  logic xtal_rise, cs_fall, wr_evt;
  logic [rtc_pkg::XDIV_W-1:0] xdiv, next_xdiv;
  logic [5:0] sub_cnt, next_sub_cnt;
  logic [4:0] run_cnt, next_run_cnt;
  logic tick_d, next_tick_d;
  logic tick_sub, hund_tick;
  logic [15:0][7:0] regs, next_regs;
  logic [15:0][7:0] snap, next_snap;
  logic next_oe;

  rtc_spi_link u_link (
    .sclk(sclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .port(link.link)
  );

  assign link.snap = snap;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bcd increment with wrap; top bit is the carry out
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    r = {1'b0, 8'(v + 8'h01)};
    if (v == last)
      r = {1'b1, first};
    else if (v[3:0] == rtc_pkg::BCD_NINE)
      r = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
    return r;
  endfunction

  // year 00 counts as leap; range ends in 2100
  function automatic logic [7:0] month_last(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    logic [7:0] d;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      rtc_pkg::MON_FEB: d = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
      rtc_pkg::MON_APR, rtc_pkg::MON_JUN, rtc_pkg::MON_SEP, rtc_pkg::MON_NOV:
        d = rtc_pkg::DAYS_30;
      default: d = rtc_pkg::DAYS_31;
    endcase
    return d;
  endfunction

  function automatic logic field_hit(input logic [7:0] a, input logic [6:0] t);
    return a[rtc_pkg::ALARM_MASK_BIT] || (a[6:0] == t);
  endfunction

  function automatic logic alarm_hit(input logic [15:0][7:0] r);
    logic [7:0] ah, ad;
    logic h_ok, d_ok;
    ah = r[rtc_pkg::REG_A_HUND];
    ad = r[rtc_pkg::REG_A_DAY];
    if (ah == rtc_pkg::ALARM_EVERY)
      h_ok = 1'b1;
    else if (ah[7:4] == rtc_pkg::ALARM_TENTHS_ANY)
      h_ok = (ah[3:0] == r[rtc_pkg::REG_HUND][3:0]);
    else
      h_ok = (ah == r[rtc_pkg::REG_HUND]);
    if (ad[rtc_pkg::ALARM_MASK_BIT])
      d_ok = 1'b1;
    else if (ad[rtc_pkg::DAYSEL_BIT])
      d_ok = (ad[3:0] == r[rtc_pkg::REG_WDAY][3:0]);
    else
      d_ok = (ad[5:0] == r[rtc_pkg::REG_MDAY][5:0]);
    return h_ok && d_ok
      && field_hit(r[rtc_pkg::REG_A_SEC], r[rtc_pkg::REG_SEC][6:0])
      && field_hit(r[rtc_pkg::REG_A_MIN], r[rtc_pkg::REG_MIN][6:0])
      && field_hit(r[rtc_pkg::REG_A_HOUR], r[rtc_pkg::REG_HOUR][6:0]);
  endfunction

  // ----------------------------------------------------------------
  // synchronisers: crystal, chip select, write toggle
  // ----------------------------------------------------------------
  always_comb
  begin
    next_sync_meta = {link.wr_tgl, cs_n, xtal_in};
    next_sync_live = sync_meta;
    next_sync_prev = sync_live;
    xtal_rise = sync_live[0] & ~sync_prev[0];
    cs_fall = ~sync_live[1] & sync_prev[1];
    wr_evt = sync_live[2] ^ sync_prev[2];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_meta <= rtc_pkg::SYNC_RESET;
      sync_live <= rtc_pkg::SYNC_RESET;
      sync_prev <= rtc_pkg::SYNC_RESET;
    end
    else if (clk_en)
    begin
      sync_meta <= next_sync_meta;
      sync_live <= next_sync_live;
      sync_prev <= next_sync_prev;
    end
  end

  // ----------------------------------------------------------------
  // crystal divider to 4096Hz, then 41x24 + 40 to 100Hz
  // ----------------------------------------------------------------
  always_comb
  begin
    next_xdiv = xdiv;
    next_sub_cnt = sub_cnt;
    next_run_cnt = run_cnt;
    tick_sub = xtal_rise && (xdiv[2:0] == rtc_pkg::PRESCALE_LAST);
    hund_tick = tick_sub && (sub_cnt == ((run_cnt == rtc_pkg::DIV_LONG_RUNS)
      ? rtc_pkg::DIV_SHORT_LAST : rtc_pkg::DIV_LONG_LAST));
    if (xtal_rise)
      next_xdiv = rtc_pkg::XDIV_W'(xdiv + 1'b1);
    if (hund_tick)
    begin
      next_sub_cnt = 6'h00;
      next_run_cnt = (run_cnt == rtc_pkg::DIV_LONG_RUNS) ? 5'h00 : 5'(run_cnt + 5'h01);
    end
    else if (tick_sub)
      next_sub_cnt = 6'(sub_cnt + 6'h01);
    next_tick_d = hund_tick;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xdiv <= '0;
      sub_cnt <= 6'h00;
      run_cnt <= 5'h00;
      tick_d <= 1'b0;
    end
    else if (clk_en)
    begin
      xdiv <= next_xdiv;
      sub_cnt <= next_sub_cnt;
      run_cnt <= next_run_cnt;
      tick_d <= next_tick_d;
    end
  end

  // ----------------------------------------------------------------
  // live registers, snapshot and output pin
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [8:0] s;
    logic c;
    logic [7:0] h;
    logic [7:0] ctl;
    logic wave;
    s = 9'h000;
    c = 1'b0;
    h = regs[rtc_pkg::REG_HOUR];
    ctl = regs[rtc_pkg::REG_CTRL];
    wave = 1'b0;
    next_regs = regs;
    next_snap = snap;
    if (hund_tick)
    begin
      s = bcd_step(regs[rtc_pkg::REG_HUND], rtc_pkg::BCD_99, rtc_pkg::BCD_ZERO);
      next_regs[rtc_pkg::REG_HUND] = s[7:0];
      c = s[8];
      s = bcd_step(regs[rtc_pkg::REG_SEC], rtc_pkg::BCD_59, rtc_pkg::BCD_ZERO);
      if (c)
        next_regs[rtc_pkg::REG_SEC] = s[7:0];
      c = c & s[8];
      s = bcd_step(regs[rtc_pkg::REG_MIN], rtc_pkg::BCD_59, rtc_pkg::BCD_ZERO);
      if (c)
        next_regs[rtc_pkg::REG_MIN] = s[7:0];
      c = c & s[8];
      if (h[rtc_pkg::HOUR_MODE_BIT])
      begin
        s = bcd_step({3'h0, h[4:0]}, rtc_pkg::BCD_12, rtc_pkg::BCD_ONE);
        if (c)
          next_regs[rtc_pkg::REG_HOUR] = {h[7:6], h[5] ^ (h[4:0] == rtc_pkg::BCD_11), s[4:0]};
        c = c & (h[4:0] == rtc_pkg::BCD_11) & h[rtc_pkg::HOUR_PM_BIT];
      end
      else
      begin
        s = bcd_step({2'h0, h[5:0]}, rtc_pkg::BCD_23, rtc_pkg::BCD_ZERO);
        if (c)
          next_regs[rtc_pkg::REG_HOUR] = {h[7:6], s[5:0]};
        c = c & s[8];
      end
      s = bcd_step(regs[rtc_pkg::REG_WDAY], rtc_pkg::BCD_7, rtc_pkg::BCD_ONE);
      if (c)
        next_regs[rtc_pkg::REG_WDAY] = s[7:0];
      s = bcd_step(regs[rtc_pkg::REG_MDAY],
        month_last(regs[rtc_pkg::REG_MON][4:0], regs[rtc_pkg::REG_YEAR]), rtc_pkg::BCD_ONE);
      if (c)
        next_regs[rtc_pkg::REG_MDAY] = s[7:0];
      c = c & s[8];
      s = bcd_step({3'h0, regs[rtc_pkg::REG_MON][4:0]}, rtc_pkg::BCD_12, rtc_pkg::BCD_ONE);
      if (c)
        next_regs[rtc_pkg::REG_MON][4:0] = s[4:0];
      c = c & s[8];
      s = bcd_step(regs[rtc_pkg::REG_YEAR], rtc_pkg::BCD_99, rtc_pkg::BCD_ZERO);
      if (c)
        next_regs[rtc_pkg::REG_YEAR] = s[7:0];
      if (c && s[8])
        next_regs[rtc_pkg::REG_MON][rtc_pkg::CENTURY_BIT] =
          ~regs[rtc_pkg::REG_MON][rtc_pkg::CENTURY_BIT];
    end
    if (wr_evt)
    begin
      // write lands in live set only
      if (link.wr_addr == rtc_pkg::REG_STAT)
        next_regs[rtc_pkg::REG_STAT] = next_regs[rtc_pkg::REG_STAT] & link.wr_data;
      else
        next_regs[link.wr_addr] = link.wr_data & rtc_pkg::REG_MASK[link.wr_addr];
    end
    // alarm flag, set beats a clearing write
    if (tick_d && alarm_hit(regs))
      next_regs[rtc_pkg::REG_STAT][rtc_pkg::ALARM_FLAG_BIT] = 1'b1;
    if (cs_fall)
      next_snap = regs;
    case ({ctl[rtc_pkg::RATE_HI_BIT], ctl[rtc_pkg::RATE_LO_BIT]})
      2'b00: wave = xdiv[rtc_pkg::WAVE_BIT_1HZ];
      2'b01: wave = xdiv[rtc_pkg::WAVE_BIT_4K];
      2'b10: wave = xdiv[rtc_pkg::WAVE_BIT_8K];
      default: wave = sync_live[0];
    endcase
    // open drain: pulled low for an active interrupt or a low wave phase
    if (ctl[rtc_pkg::IRQ_SEL_BIT])
      next_oe = ctl[rtc_pkg::AIE_BIT] & regs[rtc_pkg::REG_STAT][rtc_pkg::ALARM_FLAG_BIT];
    else
      next_oe = ~wave;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs <= rtc_pkg::REG_RESET;
      snap <= rtc_pkg::REG_RESET;
      wave_or_irq_out_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      regs <= next_regs;
      snap <= next_snap;
      wave_or_irq_out_oe <= next_oe;
    end
  end
endmodule

// ### hdl/rtc_spi_link.sv
`timescale 1ns/1ns
module rtc_spi_link (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  rtc_link_if.link port
);
  // frame state dies with chip select high; sclk may stop between frames
  logic frame_rst_n;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] shift, next_shift;
  logic have_addr, next_have_addr;
  logic is_write, next_is_write;
  logic [3:0] ptr, next_ptr;
  logic [7:0] rx_byte;
  logic byte_done;
  logic next_wr_tgl;
  logic [3:0] next_wr_addr;
  logic [7:0] next_wr_data;
  logic next_dout;

  assign frame_rst_n = rst_n & ~cs_n;

  // ----------------------------------------------------------------
  // receive and address pointer
  // ----------------------------------------------------------------
  always_comb
  begin
    rx_byte = {shift, din};
    byte_done = (bit_cnt == 3'(7));
    next_bit_cnt = 3'(bit_cnt + 3'h1);
    next_shift = rx_byte[6:0];
    next_have_addr = have_addr;
    next_is_write = is_write;
    next_ptr = ptr;
    if (byte_done)
    begin
      if (!have_addr)
      begin
        next_have_addr = 1'b1;
        next_is_write = rx_byte[rtc_pkg::WRITE_BIT];
        next_ptr = rx_byte[rtc_pkg::ADDR_W-1:0];
      end
      else
      begin
        next_ptr = 4'(ptr + 4'h1);
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      have_addr <= 1'b0;
      is_write <= 1'b0;
      ptr <= 4'h0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      have_addr <= next_have_addr;
      is_write <= next_is_write;
      ptr <= next_ptr;
    end
  end

  // ----------------------------------------------------------------
  // write hand-off, toggle crosses to the core clock
  // ----------------------------------------------------------------
  always_comb
  begin
    next_wr_tgl = port.wr_tgl;
    next_wr_addr = port.wr_addr;
    next_wr_data = port.wr_data;
    if (!cs_n && byte_done && have_addr && is_write)
    begin
      next_wr_tgl = ~port.wr_tgl;
      next_wr_addr = ptr;
      next_wr_data = rx_byte;
    end
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port.wr_tgl <= 1'b0;
      port.wr_addr <= 4'h0;
      port.wr_data <= 8'h00;
    end
    else
    begin
      port.wr_tgl <= next_wr_tgl;
      port.wr_addr <= next_wr_addr;
      port.wr_data <= next_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // read data, launched on falling sclk
  // ----------------------------------------------------------------
  always_comb
  begin
    next_dout = 1'b0;
    if (have_addr && !is_write)
      next_dout = port.snap[ptr][3'(3'h7 - bit_cnt)];
  end

  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      dout <= 1'b0;
    else
      dout <= next_dout;
  end
endmodule

// ### test/rtc_link_monitor.sv
`timescale 1ns/1ns
module rtc_link_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic xtal_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic wave_or_irq_out_oe
);
  // ----------------------------------------------------------------
  // frame tracking at the link
  // ----------------------------------------------------------------
  logic [5:0] bit_cnt;
  logic [5:0] next_bit_cnt;
  logic wr_frame;
  logic next_wr_frame;
  // counter saturates so long frames never alias the address byte
  always_comb
  begin
    next_bit_cnt = (bit_cnt == 6'h3F) ? bit_cnt : bit_cnt + 6'h01;
    next_wr_frame = (bit_cnt == 6'h00) ? din : wr_frame;
  end
  always_ff @(posedge sclk or negedge rst_n or posedge cs_n)
  begin
    if (!rst_n || cs_n)
    begin
      bit_cnt <= 6'h00;
      wr_frame <= 1'b0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      wr_frame <= next_wr_frame;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence frame_open_s;
    !cs_n && !$past(cs_n);
  endsequence
  sequence sclk_high_s;
    sclk && $past(sclk);
  endsequence
  dout_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> !dout) else $error("dout driven while deselected");
  dout_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_open_s ##0 sclk_high_s |-> $stable(dout)) else $error("dout moved while sclk high");
  dout_on_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_open_s ##0 $changed(dout) |-> !sclk) else $error("dout moved off the falling edge");
  addr_quiet_a: assert property (@(posedge sclk) disable iff (!rst_n)
    bit_cnt < 6'h08 |-> !dout) else $error("dout busy during address byte");
  write_quiet_a: assert property (@(posedge sclk) disable iff (!rst_n)
    wr_frame && bit_cnt != 6'h00 |-> !dout) else $error("dout busy in a write frame");
  oe_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(clk_en) |-> $stable(wave_or_irq_out_oe)) else $error("pin moved while frozen");
  // a control write mid-frame may legally cut one short phase at the mode switch
  oe_settle_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n && $changed(wave_or_irq_out_oe) |=> $stable(wave_or_irq_out_oe))
    else $error("pin glitched for one cycle");
  oe_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> !wave_or_irq_out_oe) else $error("pin driven at reset release");
endmodule

bind rtc_register_map_snapshot rtc_link_monitor monitor_u (.clk(clk), .rst_n(rst_n),
  .clk_en(clk_en), .xtal_in(xtal_in), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
  .wave_or_irq_out_oe(wave_or_irq_out_oe));

// ### test/rtc_register_map_snapshot_tb.sv
`timescale 1ns/1ns
module rtc_register_map_snapshot_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic xtal_in = 1'b0;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic wave_or_irq_out_oe;
  logic wave_pin;
  int fail_count = 0;
  int n_checks = 0;
  int toggles;
  logic prev_pin;
  logic [7:0] first_hund;
  logic [23:0] rows [0:9];
  int span [0:3][0:2];
  logic [7:0] reset_val [0:15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] roll_set [0:7] = '{8'h95, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0] roll_exp [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00};
  logic [7:0] half_exp [0:2] = '{8'h52, 8'h02, 8'h02};
  always #2 clk = ~clk;
  // crystal sped up so hundredths tick every 6.56 us
  always #10 xtal_in = ~xtal_in;
  // open drain with pull-up
  assign wave_pin = wave_or_irq_out_oe ? 1'b0 : 1'b1;
  rtc_register_map_snapshot dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .xtal_in(xtal_in), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .wave_or_irq_out_oe(wave_or_irq_out_oe));
  rtc_serial_master master_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    @(posedge clk);
    #1;
    master_u.xfer(a, n);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    master_u.wbuf[0] = d;
    rd(8'h80 | a, 1);
  endtask
  task automatic final_report;
    $display("Checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // nearly twice the expected run
  initial
  begin
    #300000;
    fail_count++;
    $display("Error at %0t ns: run timed out", $time);
    final_report();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{24'h0DFFBD, 24'h0FA5A5, 24'h04FD05, 24'h067F1F, 24'h074242,
      24'h09FFFF, 24'h0AFFFF, 24'h0BFFFF, 24'h0CFFFF, 24'h08FFFF};
    span = '{'{24, 140, 180}, '{16, 36, 44}, '{8, 17, 23}, '{0, 0, 1}};
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00, 33);
    first_hund = master_u.rbuf[0];
    check(master_u.rbuf[16], first_hund);
    check(master_u.rbuf[32], first_hund);
    for (int i = 2; i < 16; i++)
      check(master_u.rbuf[i], reset_val[i]);
    rd(8'h00, 1);
    n_checks++;
    if (master_u.rbuf[0] === first_hund)
    begin
      fail_count++;
      $display("Error at %0t ns: live count stood still", $time);
    end
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 1);
      check(master_u.rbuf[0], rows[i][7:0]);
    end
    repeat (4000) @(posedge clk);
    rd(8'h0E, 1);
    check(master_u.rbuf[0], 8'h81);
    check({7'h00, wave_pin}, 8'h00);
    wr(8'h08, 8'h99);
    wr(8'h0E, 8'h80);
    rd(8'h0E, 1);
    check(master_u.rbuf[0], 8'h80);
    check({7'h00, wave_pin}, 8'h01);
    foreach (span[i])
    begin
      wr(8'h0D, span[i][0][7:0]);
      toggles = 0;
      repeat (400)
      begin
        prev_pin = wave_pin;
        @(posedge clk);
        #1;
        if (wave_pin !== prev_pin)
          toggles++;
      end
      n_checks++;
      if (toggles < span[i][1] || toggles > span[i][2])
      begin
        fail_count++;
        $display("Error at %0t ns: %0d wave toggles at rate %0d", $time, toggles, i);
      end
    end
    wr(8'h0D, 8'h18);
    @(posedge clk);
    #1 clk_en = 1'b0;
    prev_pin = wave_pin;
    repeat (50) @(posedge clk);
    check({7'h00, wave_pin}, {7'h00, prev_pin});
    #1 clk_en = 1'b1;
    // select just after a wave rise
    @(posedge wave_pin);
    // hundredths then seconds, reread until two agree
    for (int a = 0; a < 2; a++)
    begin
      toggles = 0;
      do
      begin
        rd(8'(a), 1);
        first_hund = master_u.rbuf[0];
        rd(8'(a), 1);
        toggles++;
      end
      while (master_u.rbuf[0] !== first_hund && toggles < 4);
      check(master_u.rbuf[0], first_hund);
    end
    for (int i = 0; i < 8; i++)
      master_u.wbuf[i] = roll_set[i];
    rd(8'h80, 8);
    repeat (10000) @(posedge clk);
    rd(8'h01, 7);
    for (int i = 0; i < 7; i++)
      check(master_u.rbuf[i], roll_exp[i]);
    for (int i = 0; i < 3; i++)
      master_u.wbuf[i] = roll_set[i];
    master_u.wbuf[3] = 8'h71;
    rd(8'h80, 4);
    repeat (10000) @(posedge clk);
    rd(8'h03, 3);
    for (int i = 0; i < 3; i++)
      check(master_u.rbuf[i], half_exp[i]);
    final_report();
  end
endmodule

// ### test/rtc_serial_master.sv
`timescale 1ns/1ns
module rtc_serial_master (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [7:0] wbuf [0:47];
  logic [7:0] rbuf [0:47];
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    // read frames still clock out defined filler
    foreach (wbuf[i])
      wbuf[i] = 8'h00;
  end
  // ----------------------------------------------------------------
  // byte and frame transfer, 48 ns link clock
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      din = tx[b];
      #24 sclk = 1'b1;
      rx[b] = dout;
      #24 sclk = 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    cs_n = 1'b0;
    // even lead after the odd start in rd keeps link edges off the core clock edges
    #22;
    send_byte(cmd, junk);
    for (int i = 0; i < n; i++)
      send_byte(wbuf[i], rbuf[i]);
    #24 cs_n = 1'b1;
    // released line shows no stale level; sclk stands low
    din = ~din;
    #48;
  endtask
endmodule
